// *** design/fdc_consts.svh ***
`ifndef FDC_CONSTS_SVH
`define FDC_CONSTS_SVH

// ==========================================================================
// clock and timing
`define FDC_CLK_NS         5
`define FDC_SETUP_NS       10
`define FDC_WE_LOW_NS      50
`define FDC_HOLD_NS        10
`define FDC_ACC_NS         150
`define FDC_RECOVERY_NS    1000
`define FDC_SETTLE_NS      100
`define FDC_SYNC_STAGES    2
// least times round up to whole cycles
`define FDC_SETUP_CYC      ((`FDC_SETUP_NS + `FDC_CLK_NS - 1) / `FDC_CLK_NS)
`define FDC_WE_LOW_CYC     ((`FDC_WE_LOW_NS + `FDC_CLK_NS - 1) / `FDC_CLK_NS)
`define FDC_HOLD_CYC       ((`FDC_HOLD_NS + `FDC_CLK_NS - 1) / `FDC_CLK_NS)
`define FDC_ACC_CYC        ((`FDC_ACC_NS + `FDC_CLK_NS - 1) / `FDC_CLK_NS)
`define FDC_RECOVERY_CYC   ((`FDC_RECOVERY_NS + `FDC_CLK_NS - 1) / `FDC_CLK_NS)
`define FDC_SETTLE_CYC     ((`FDC_SETTLE_NS + `FDC_CLK_NS - 1) / `FDC_CLK_NS)

// ==========================================================================
// register offsets (byte addresses)
`define FDC_OFF_CTRL       12'h000
`define FDC_OFF_ADDR       12'h004
`define FDC_OFF_WDATA      12'h008
`define FDC_OFF_CMD        12'h00c
`define FDC_OFF_STATUS     12'h010
`define FDC_OFF_RDATA      12'h014

// ==========================================================================
// field positions
`define FDC_CTRL_RUN       0
`define FDC_CTRL_WP        1
`define FDC_CTRL_WORD      2
`define FDC_CMD_START      0
`define FDC_CMD_READ       1
`define FDC_CMD_PE         2
`define FDC_CMD_STAT       3
`define FDC_ST_BUSY        0
`define FDC_ST_RB          1
`define FDC_ST_RECOV       2
`define FDC_ST_REFUSED     3
`define FDC_ST_PE_ACTIVE   4
`define FDC_ST_PE_DIE      5
`define FDC_DIE_BIT        21

// ==========================================================================
// reset values
`define FDC_CTRL_RST       3'h0

`endif

// *** design/fdc_pkg.sv ***
`default_nettype none

package fdc_pkg;

    // ======================================================================
    // cycle sequencer states
    typedef enum logic [2:0] {
        FDC_IDLE,
        FDC_SETUP,
        FDC_STROBE,
        FDC_HOLD,
        FDC_SAMPLE
    } fdc_state_t;

    // ======================================================================
    // flash control pins, all active low except width select
    typedef struct packed {
        logic common_chip_enable_n;
        logic die_one_select_n;
        logic die_two_select_n;
        logic oe_n;
        logic we_n;
        logic reset_powerdown_n;
        logic write_protect_n;
        logic width_select;
    } fdc_ctl_t;

endpackage : fdc_pkg

`default_nettype wire

// *** design/fdc_sync2.sv ***
`default_nettype none

// ==========================================================================
// two-flop synchroniser for pin inputs
module fdc_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // pins and synchronised copy
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1_r;

    // first stage read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            q    <= '0;
        end else begin
            s1_r <= d;
            q    <= s1_r;
        end
    end

endmodule : fdc_sync2

`default_nettype wire

// *** design/fdc_flash_host.sv ***
// The implementer's own choices: the APB register port and the address map.
`default_nettype none
`include "fdc_consts.svh"

// What this block does
// - operations issued only as command write cycles
// - refuse other die while program/erase runs
// - never both die selects low together
// - wait recovery time after powerdown release
module fdc_flash_host (
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // flash control and address pins
    output fdc_pkg::fdc_ctl_t  flash_ctl,
    output logic      [20:0]   flash_addr,
    // flash data pins
    output logic      [15:0]   dq_out,
    output logic      [15:0]   dq_oe_n,
    input  wire logic [15:0]   dq_in,
    // flash ready/busy pin
    input  wire logic          ready_busy_n
);
    import fdc_pkg::*;

    // ======================================================================
    // declarations
    fdc_state_t   state_r, state_nxt;
    logic [11:0]  cnt_r, cnt_nxt;
    logic [11:0]  recov_r, recov_nxt;
    logic [11:0]  settle_r, settle_nxt;
    logic [2:0]   ctrl_r;
    logic [21:0]  addr_r;
    logic [15:0]  wdata_r;
    logic [15:0]  rdata_r;
    logic [21:0]  op_addr_r;
    logic [15:0]  op_data_r;
    logic         op_rd_r;
    logic         op_stat_r;
    logic         refused_r;
    logic         pe_valid_r;
    logic         pe_die_r;
    logic         run_prev_r;
    logic [15:0]  dq_sync;
    logic         rb_sync;
    fdc_ctl_t     ctl_nxt;
    logic [20:0]  faddr_nxt;
    logic [15:0]  dq_oe_n_nxt;
    logic [31:0]  rd_mux;

    // ======================================================================
    // pin synchronisers
    fdc_sync2 #(.W(17)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({ready_busy_n, dq_in}),
        .q       ({rb_sync, dq_sync})
    );

    // ======================================================================
    // apb decode
    wire setup_ph   = psel & ~penable;
    wire acc_wr     = psel & penable & pready & pwrite;
    wire hit_ctrl   = (paddr == `FDC_OFF_CTRL);
    wire hit_addr   = (paddr == `FDC_OFF_ADDR);
    wire hit_wdata  = (paddr == `FDC_OFF_WDATA);
    wire hit_cmd    = (paddr == `FDC_OFF_CMD);
    wire hit_status = (paddr == `FDC_OFF_STATUS);
    wire hit_rdata  = (paddr == `FDC_OFF_RDATA);
    wire hit_any    = hit_ctrl | hit_addr | hit_wdata | hit_cmd | hit_status | hit_rdata;

    // ======================================================================
    // request qualification
    wire run        = ctrl_r[`FDC_CTRL_RUN];
    wire word_mode  = ctrl_r[`FDC_CTRL_WORD];
    wire req        = acc_wr & hit_cmd & pwdata[`FDC_CMD_START];
    wire req_die    = addr_r[`FDC_DIE_BIT];
    wire conflict   = pe_valid_r & (req_die != pe_die_r);
    wire idle       = (state_r == FDC_IDLE);
    wire start_ok   = req & idle & run & (recov_r == 12'h000) & ~conflict;
    wire refuse     = req & ~start_ok;
    wire clr_ref    = acc_wr & hit_status & pwdata[`FDC_ST_REFUSED];
    wire run_rise   = run & ~run_prev_r;
    wire pe_start   = start_ok & pwdata[`FDC_CMD_PE] & ~pwdata[`FDC_CMD_READ];
    wire pe_done    = idle & (settle_r == 12'h000) & rb_sync;
    wire cnt_zero   = (cnt_r == 12'h000);

    // ======================================================================
    // readback mux
    assign rd_mux =
        hit_ctrl   ? {29'h0, ctrl_r} :
        hit_addr   ? {10'h0, addr_r} :
        hit_wdata  ? {16'h0, wdata_r} :
        hit_status ? {26'h0, pe_die_r, pe_valid_r, refused_r,
                      (recov_r != 12'h000), rb_sync, ~idle} :
        hit_rdata  ? {16'h0, rdata_r} :
        32'h0;

    // ======================================================================
    // cycle sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_zero ? 12'h000 : cnt_r - 12'h001;
        unique case (state_r)
            FDC_IDLE: begin
                if (start_ok) begin
                    state_nxt = FDC_SETUP;
                    cnt_nxt   = 12'(`FDC_SETUP_CYC - 1);
                end
            end
            FDC_SETUP: begin
                if (cnt_zero) begin
                    state_nxt = FDC_STROBE;
                    cnt_nxt   = op_rd_r ? 12'(`FDC_ACC_CYC + `FDC_SYNC_STAGES - 1)
                                        : 12'(`FDC_WE_LOW_CYC - 1);
                end
            end
            FDC_STROBE: begin
                if (cnt_zero) begin
                    state_nxt = op_rd_r ? FDC_SAMPLE : FDC_HOLD;
                    cnt_nxt   = 12'(`FDC_HOLD_CYC - 1);
                end
            end
            FDC_HOLD: begin
                if (cnt_zero) begin
                    state_nxt = FDC_IDLE;
                end
            end
            FDC_SAMPLE: begin
                state_nxt = FDC_IDLE;
            end
        endcase
        if (!run) begin
            state_nxt = FDC_IDLE;
            cnt_nxt   = 12'h000;
        end
    end

    // ======================================================================
    // timers for recovery and die busy settle
    assign recov_nxt  = !run     ? 12'h000 :
                        run_rise ? 12'(`FDC_RECOVERY_CYC) :
                        (recov_r != 12'h000) ? recov_r - 12'h001 : 12'h000;
    assign settle_nxt = pe_start ? 12'(`FDC_SETTLE_CYC) :
                        (idle && settle_r != 12'h000) ? settle_r - 12'h001 : settle_r;

    // ======================================================================
    // pin values for the next cycle
    wire sel_nxt  = (state_nxt != FDC_IDLE);
    wire die_nxt  = start_ok ? req_die : op_addr_r[`FDC_DIE_BIT];
    wire rd_nxt   = start_ok ? pwdata[`FDC_CMD_READ] : op_rd_r;
    wire [21:0] a_nxt = start_ok ? addr_r : op_addr_r;
    always_comb begin
        ctl_nxt.common_chip_enable_n = ~sel_nxt;
        ctl_nxt.die_one_select_n     = ~(sel_nxt & ~die_nxt);
        ctl_nxt.die_two_select_n     = ~(sel_nxt & die_nxt);
        ctl_nxt.oe_n                 = ~(sel_nxt & rd_nxt);
        ctl_nxt.we_n                 = ~((state_nxt == FDC_STROBE) & ~rd_nxt);
        ctl_nxt.reset_powerdown_n    = run;
        ctl_nxt.write_protect_n      = run & ctrl_r[`FDC_CTRL_WP];
        ctl_nxt.width_select         = word_mode;
    end
    // byte address in x8, a0 held low in x16
    assign faddr_nxt = word_mode ? {a_nxt[20:1], 1'b0} : a_nxt[20:0];

    // ======================================================================
    // data drive enables, high byte idle in x8 mode
    wire drv_nxt = sel_nxt & ~rd_nxt;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_dq
            if (gi < 8) begin : g_lo
                assign dq_oe_n_nxt[gi] = ~drv_nxt;
            end else begin : g_hi
                assign dq_oe_n_nxt[gi] = ~(drv_nxt & word_mode);
            end
        end
    endgenerate

    // ======================================================================
    // apb registers and answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r  <= `FDC_CTRL_RST;
            addr_r  <= 22'h0;
            wdata_r <= 16'h0;
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            if (acc_wr && hit_ctrl)  ctrl_r  <= pwdata[2:0];
            if (acc_wr && hit_addr)  addr_r  <= pwdata[21:0];
            if (acc_wr && hit_wdata) wdata_r <= pwdata[15:0];
            prdata  <= setup_ph ? rd_mux : 32'h0;
            pready  <= setup_ph;
            pslverr <= setup_ph & ~hit_any;
        end
    end

    // ======================================================================
    // sequencer, timers and flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r    <= FDC_IDLE;
            cnt_r      <= 12'h000;
            recov_r    <= 12'h000;
            settle_r   <= 12'h000;
            run_prev_r <= 1'b0;
            refused_r  <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            recov_r    <= recov_nxt;
            settle_r   <= settle_nxt;
            run_prev_r <= run;
            refused_r  <= refuse | (refused_r & ~clr_ref);
        end
    end

    // ======================================================================
    // die busy tracking; aborted by powerdown
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pe_valid_r <= 1'b0;
            pe_die_r   <= 1'b0;
        end else if (!run) begin
            pe_valid_r <= 1'b0;
        end else if (pe_start) begin
            pe_valid_r <= 1'b1;
            pe_die_r   <= req_die;
        end else if (pe_done) begin
            pe_valid_r <= 1'b0;
        end
    end

    // ======================================================================
    // latched operation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_addr_r <= 22'h0;
            op_data_r <= 16'h0;
            op_rd_r   <= 1'b0;
            op_stat_r <= 1'b0;
        end else if (start_ok) begin
            op_addr_r <= addr_r;
            op_data_r <= wdata_r;
            op_rd_r   <= pwdata[`FDC_CMD_READ];
            op_stat_r <= pwdata[`FDC_CMD_STAT];
        end
    end

    // ======================================================================
    // read capture; high byte dropped in x8 and status reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 16'h0;
        end else if (state_r == FDC_SAMPLE) begin
            rdata_r <= (word_mode && !op_stat_r) ? dq_sync
                                                 : {8'h00, dq_sync[7:0]};
        end
    end

    // ======================================================================
    // pin registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_ctl  <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
            flash_addr <= 21'h0;
            dq_out     <= 16'h0;
            dq_oe_n    <= 16'hffff;
        end else begin
            flash_ctl  <= ctl_nxt;
            flash_addr <= faddr_nxt;
            dq_out     <= start_ok ? wdata_r : op_data_r;
            dq_oe_n    <= dq_oe_n_nxt;
        end
    end

endmodule : fdc_flash_host

`default_nettype wire

// *** verif/fdc_flash_host_checker.sv ***
`default_nettype none

// ==========================================================================
// pin checker for the flash host
module fdc_flash_host_checker (
    // clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // flash pins
    input wire fdc_pkg::fdc_ctl_t flash_ctl,
    input wire logic [20:0]       flash_addr,
    input wire logic [15:0]       dq_out,
    input wire logic [15:0]       dq_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    import fdc_pkg::*;
    logic       ce_n, d1_n, d2_n, oe_n, we_n, awake, wp_n, wide;
    logic [7:0] we_cnt_r;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // short names for the pins
    assign {ce_n, d1_n, d2_n, oe_n, we_n, awake, wp_n, wide} = flash_ctl;
    // cycles of the current write strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            we_cnt_r <= 8'h00;
        else
            we_cnt_r <= we_n ? 8'h00 : we_cnt_r + 8'h01;
    end
    chk_die_excl: assert property (
        d1_n || d2_n) else $error("both dies selected");
    chk_one_die: assert property (
        !ce_n |-> d1_n != d2_n) else $error("no single die");
    chk_pd_wp: assert property (
        !awake |-> !wp_n) else $error("protect high in powerdown");
    chk_pd_quiet: assert property (
        !awake [*2] |-> ce_n && we_n && oe_n && &dq_oe_n) else $error("cycle in powerdown");
    chk_read_float: assert property (
        !oe_n |-> we_n && &dq_oe_n) else $error("drive during read");
    chk_byte_high: assert property (
        !wide |-> &dq_oe_n[15:8]) else $error("high byte driven in x8");
    chk_word_a0: assert property (
        wide && !ce_n |-> !flash_addr[0]) else $error("bit zero set in x16");
    chk_strobe_len: assert property (
        $rose(we_n) && awake |-> we_cnt_r == 8'h0a) else $error("strobe length");
    chk_write_hold: assert property (
        $rose(we_n) && awake |-> (!ce_n && $stable(flash_addr) && $stable(dq_out)) [*2])
        else $error("write hold broken");
    // main scenarios
    cov_write: cover property ($rose(we_n) && awake);
    cov_read: cover property ($fell(oe_n));
    cov_pd: cover property ($fell(awake));
endmodule : fdc_flash_host_checker

bind fdc_flash_host fdc_flash_host_checker i_fdc_flash_host_checker (
    .pclk(pclk), .presetn(presetn), .flash_ctl(flash_ctl),
    .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n)
);

`default_nettype wire

// *** verif/fdc_flash_model.sv ***
`default_nettype none

// ==========================================================================
// behavioural flash pair seen from its pins
module fdc_flash_model #(
    parameter int BUSY_CYC = 300
) (
    // timing clock
    input  wire logic              pclk,
    // pins from the host
    input  wire fdc_pkg::fdc_ctl_t flash_ctl,
    input  wire logic [20:0]       flash_addr,
    input  wire logic [15:0]       dq_out,
    input  wire logic [15:0]       dq_oe_n,
    // pins to the host
    output logic      [15:0]       dq_in,
    output logic                   ready_busy_n
);
    timeunit 1ns;
    timeprecision 1ps;
    import fdc_pkg::*;
    logic [38:0] got_q[$];
    logic [15:0] wd;
    logic        sel, we_q;
    int          busy_cnt;
    // selection and read pattern
    assign sel = flash_ctl.reset_powerdown_n && !flash_ctl.common_chip_enable_n
        && (flash_ctl.die_one_select_n ^ flash_ctl.die_two_select_n);
    assign wd = flash_addr[16:1] ^ 16'h3c5a;
    initial begin
        dq_in = 16'h0000;
        ready_busy_n = 1'b1;
        busy_cnt = 0;
        we_q = 1'b1;
    end
    // capture on strobe rise, busy timer, read drive or invert dq_in
    always @(posedge pclk) begin
        we_q <= flash_ctl.we_n;
        if (sel && flash_ctl.we_n && !we_q) begin
            got_q.push_back({flash_ctl.write_protect_n, flash_ctl.die_one_select_n, flash_addr,
                flash_ctl.width_select ? dq_out : {8'h00, dq_out[7:0]}});
            busy_cnt <= BUSY_CYC;
        end else if (busy_cnt > 0)
            busy_cnt <= busy_cnt - 1;
        if (!flash_ctl.reset_powerdown_n)
            busy_cnt <= 0;
        ready_busy_n <= !(busy_cnt > 0 && flash_ctl.reset_powerdown_n);
        if (sel && !flash_ctl.oe_n && flash_ctl.we_n)
            dq_in <= flash_ctl.width_select ? wd
                : {~dq_in[15:8], flash_addr[0] ? wd[15:8] : wd[7:0]};
        else
            dq_in <= ~dq_in;
    end
endmodule : fdc_flash_model

`default_nettype wire

// *** verif/fdc_flash_host_test.sv ***
`default_nettype none

`define FDC_CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %0t: got %h exp %h", $time, g, e); end end

// ==========================================================================
// self-checking bench for the flash host
module fdc_flash_host_test;
    timeunit 1ns;
    timeprecision 1ps;
    import fdc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rb_n, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rq, lfsr_r;
    logic [20:0] faddr;
    logic [15:0] dq_out, dq_oe_n, dq_in, wd;
    logic [38:0] exp_q[$];
    fdc_ctl_t    fctl;
    int          bad_count, n_checks, cyc;

    fdc_flash_host i_fdc_flash_host (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_ctl(fctl), .flash_addr(faddr), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .dq_in(dq_in), .ready_busy_n(rb_n)
    );
    fdc_flash_model i_fdc_flash_model (
        .pclk(pclk), .flash_ctl(fctl), .flash_addr(faddr), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .dq_in(dq_in), .ready_busy_n(rb_n)
    );
    // clock and hang guard
    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            test_done();
        end
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic test_done;
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done
    // one apb transfer, result left in rq and rerr
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rq   = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // poll status until a bit drops
    task automatic wait_clear(input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, 12'h010, 32'h0);
            n++;
        end while (rq[b] !== 1'b0 && n < 100);
        `FDC_CHK(rq[b], 1'b0)
    endtask : wait_clear
    task automatic op(input logic [3:0] c);
        apb(1'b1, 12'h00c, {28'h0, c});
        wait_clear(0);
    endtask : op
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        lfsr_r = 32'h0b25a280;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // reset state and an unmapped place
        apb(1'b0, 12'h000, 32'h0);
        `FDC_CHK(rq, 32'h0)
        apb(1'b1, 12'h018, 32'h5);
        `FDC_CHK(rerr, 1'b1)
        apb(1'b0, 12'h010, 32'h0);
        `FDC_CHK(rq[5:0], 6'h02)
        // leave powerdown, start refused while recovering
        apb(1'b1, 12'h000, 32'h7);
        apb(1'b0, 12'h000, 32'h0);
        `FDC_CHK(rq, 32'h7)
        apb(1'b1, 12'h00c, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        `FDC_CHK(rq[3:2], 2'b11)
        wait_clear(2);
        apb(1'b1, 12'h010, 32'h8);
        // write then read in both widths, protect on and off
        for (int i = 0; i < 4; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            apb(1'b1, 12'h000, {29'h0, i[0], i[1], 1'b1});
            apb(1'b1, 12'h004, {10'h0, lfsr_r[21:0]});
            apb(1'b1, 12'h008, {16'h0, lfsr_r[31:16]});
            op(4'h1);
            `FDC_CHK(rq[3], 1'b0)
            exp_q.push_back({i[1], lfsr_r[21:1], lfsr_r[0] & !i[0],
                i[0] ? lfsr_r[31:16] : {8'h00, lfsr_r[23:16]}});
            op({i[1] & i[0], 3'h3});
            wd = lfsr_r[16:1] ^ 16'h3c5a;
            if (!i[0])
                wd = {8'h00, lfsr_r[0] ? wd[15:8] : wd[7:0]};
            else if (i[1])
                wd = {8'h00, wd[7:0]};
            apb(1'b0, 12'h014, 32'h0);
            `FDC_CHK(rq, {16'h0, wd})
        end
        // program on die zero; other die refused, same die accepted
        apb(1'b1, 12'h000, 32'h7);
        apb(1'b1, 12'h004, 32'h0);
        op(4'h5);
        exp_q.push_back({2'b10, 21'h0, lfsr_r[31:16]});
        apb(1'b0, 12'h010, 32'h0);
        `FDC_CHK(rq[5:4], 2'b01)
        `FDC_CHK(rq[1], 1'b0)
        apb(1'b1, 12'h004, 32'h00200000);
        apb(1'b1, 12'h00c, 32'h5);
        apb(1'b0, 12'h010, 32'h0);
        `FDC_CHK(rq[3], 1'b1)
        apb(1'b1, 12'h010, 32'h8);
        apb(1'b1, 12'h004, 32'h00010000);
        op(4'h5);
        exp_q.push_back({2'b10, 21'h10000, lfsr_r[31:16]});
        `FDC_CHK(rq[3], 1'b0)
        // powerdown aborts tracking and refuses starts
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h00c, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        `FDC_CHK(rq[4:1], 4'b0101)
        `FDC_CHK(i_fdc_flash_model.got_q.size(), exp_q.size())
        foreach (exp_q[k])
            `FDC_CHK(i_fdc_flash_model.got_q[k], exp_q[k])
        test_done();
    end
endmodule : fdc_flash_host_test

`default_nettype wire
